// *** rtl/cell_framer_pkg.sv ***
// types shared by the cell output framer
`default_nettype none

package cell_framer_pkg;

  typedef enum logic [1:0] {
    GROUP_X4,
    GROUP_X8,
    GROUP_X16,
    GROUP_X32
  } group_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_MARK,
    TX_DATA
  } tx_state_t;

  typedef struct packed {
    logic [2:0] port;
    logic [7:0] data;
  } cell_byte_t;

  typedef struct packed {
    logic [3:0] nibble;
    logic       marker;
  } port_out_t;

endpackage : cell_framer_pkg

`default_nettype wire

// *** rtl/cell_framer_regs.svh ***
// register offsets, field positions, reset values and timing of the cell output framer
`ifndef CELL_FRAMER_REGS_SVH
`define CELL_FRAMER_REGS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define CFG_OFFSET         8'h00
`define ARB_OFFSET         8'h04
`define STATUS_OFFSET      8'h08

// ==========================================================================
// configuration register fields
`define CFG_LEN_LSB        0
`define CFG_LEN_MSB        5
`define CFG_START_LSB      8
`define CFG_START_MSB      13
`define CFG_GROUP_LSB      16
`define CFG_GROUP_MSB      17
`define CFG_CELLBUS_BIT    20
`define CFG_CONTROL_OUTPUT_GATE_BIT      24

// ==========================================================================
// reset values
`define CFG_LEN_RESET      6'h35
`define CFG_START_RESET    6'h00
`define CFG_GROUP_RESET    2'h0
`define CFG_CONTROL_OUTPUT_GATE_RESET    1'b1

// ==========================================================================
// cell layout and timing
`define DUMMY_BYTE_POS     6'h08
`define DUMMY_BYTE_VALUE   8'h00
`define LINK_PERIOD_NS     80
`define CLK_PERIOD_NS      5
`define LINK_CYCLES        (`LINK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// *** rtl/cell_output_port_framing.sv ***
// cell output framer: eight nibble ports on sampled port clocks, fed by a byte fifo
// Behaviour
// R1 - each port updates nibble and marker only on the rising edge of its own port clock, or of the leader's clock when grouped
// R2 - a stopped port clock freezes the cell; output resumes where it stopped
// R3 - marker goes high one port cycle before the first nibble of each cell
// R4 - a high sensed on the marker line loads the start byte address
// R5 - in cell bus mode marker lines 1 to 7 carry arbitration, line 0 does not
// R6 - eight 4-bit output ports, bit 3 most significant
// R7 - ports group into wider ports following the group leader's clock and marker
// R8 - control outputs drive only with gate pin, output enable and config bit low
// R9 - add pin inserts a dummy ninth byte in 4-bit or 8-bit mode
// R10 - drop pin removes the ninth byte in 4-bit or 8-bit mode
// R11 - add and drop pins are held static by the system
// R12 - all outputs released while output enable input is high
// R13 - after the marker, consecutive nibbles flow until the cell length is sent
`include "cell_framer_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// two flip-flop synchroniser
module sync2 #(parameter int W = 1) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync2

// ==========================================================================
// byte fifo
module cell_fifo #(parameter int WIDTH = 11, parameter int DEPTH = 4) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp];
  assign out_valid = (cnt != '0);
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp       <= '0;
      rp       <= '0;
      cnt      <= '0;
      in_ready <= 1'b1;
    end else begin
      wp       <= push ? wp + 1'b1 : wp;
      rp       <= pop ? rp + 1'b1 : rp;
      cnt      <= cnt + (AW+1)'(push) - (AW+1)'(pop);
      in_ready <= (cnt + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
    end
  end
endmodule : cell_fifo

// ==========================================================================
// one port: byte hold, dummy byte handling, nibble sequencing
module port_tx (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clk_edge,
  input  wire logic       sensed,
  input  wire logic [5:0] cell_len,
  input  wire logic [5:0] start,
  input  wire logic       narrow,
  input  wire logic       add_dummy,
  input  wire logic       drop_dummy,
  input  wire logic       hit,
  input  wire logic [7:0] byte_in,
  output logic            take,
  output cell_framer_pkg::port_out_t pout,
  output logic            busy,
  output logic            hold_v
);
  cell_framer_pkg::tx_state_t state;
  logic [7:0] hold;
  logic [5:0] byte_idx;
  logic [5:0] fcnt;
  logic       half;
  logic       load;
  logic       consume;
  logic       ins;
  logic       dummy_pos;
  logic       fetch_last;

  assign dummy_pos = narrow && (fcnt == `DUMMY_BYTE_POS);
  // a dropped ninth byte still counts as one fetched byte of the cell
  assign fetch_last = (fcnt == ((narrow && drop_dummy) ? cell_len : cell_len - 6'h01));  // R10
  assign ins       = !hold_v && dummy_pos && add_dummy;
  assign take      = !hold_v && hit && !ins;
  assign load      = clk_edge && (sensed || state == cell_framer_pkg::TX_MARK);  // R4
  assign consume   = clk_edge && !load && state == cell_framer_pkg::TX_DATA && half;
  assign busy      = (state != cell_framer_pkg::TX_IDLE);

  // fetch side: bytes in, dummy ninth byte added or dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold   <= 8'h00;
      hold_v <= 1'b0;
      fcnt   <= 6'h00;
    end else if (consume) begin
      hold_v <= 1'b0;
    end else if (ins) begin
      hold   <= `DUMMY_BYTE_VALUE;  // R9
      hold_v <= 1'b1;
      fcnt   <= fetch_last ? 6'h00 : fcnt + 6'h01;
    end else if (take) begin
      hold   <= byte_in;
      hold_v <= !(dummy_pos && drop_dummy);  // R10
      fcnt   <= fetch_last ? 6'h00 : fcnt + 6'h01;
    end
  end

  // link side: changes only on a sampled port clock edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= cell_framer_pkg::TX_IDLE;
      pout     <= '0;
      byte_idx <= 6'h00;
      half     <= 1'b0;
    end else if (clk_edge) begin  // R1 R2
      pout.marker <= 1'b0;
      if (load) begin
        pout.nibble <= hold_v ? hold[7:4] : 4'h0;  // R6
        half        <= 1'b1;
        byte_idx    <= start;  // R4
        state       <= cell_framer_pkg::TX_DATA;
      end else begin
        case (state)
          cell_framer_pkg::TX_IDLE: begin
            if (hold_v) begin
              pout.marker <= 1'b1;  // R3
              state       <= cell_framer_pkg::TX_MARK;
            end
          end
          cell_framer_pkg::TX_DATA: begin  // R13
            if (!half) begin
              pout.nibble <= hold_v ? hold[7:4] : 4'h0;
              half        <= 1'b1;
            end else begin
              pout.nibble <= hold[3:0];
              half        <= 1'b0;
              if (byte_idx >= cell_len - 6'h01) begin
                state <= cell_framer_pkg::TX_IDLE;
              end else begin
                byte_idx <= byte_idx + 6'h01;
              end
            end
          end
          default: state <= cell_framer_pkg::TX_IDLE;
        endcase
      end
    end
  end

  a_marker_then_nibble: assert property (@(posedge clk) disable iff (!rstn)  // R3
    (clk_edge && state == cell_framer_pkg::TX_IDLE && hold_v && !sensed)
      |=> pout.marker && state == cell_framer_pkg::TX_MARK)
    else $error("marker not raised before cell");
  a_sensed_loads_start: assert property (@(posedge clk) disable iff (!rstn)  // R4
    (clk_edge && sensed) |=> byte_idx == $past(start) && half && !pout.marker)
    else $error("start address not loaded on marker");
  a_frozen_without_edge: assert property (@(posedge clk) disable iff (!rstn)  // R2
    !clk_edge |=> $stable(pout) && $stable(byte_idx) && $stable(state))
    else $error("port changed without a port clock edge");
  a_dummy_inserted: assert property (@(posedge clk) disable iff (!rstn)  // R9
    ins |=> hold_v && hold == `DUMMY_BYTE_VALUE && !$past(take))
    else $error("dummy byte not inserted");
  a_ninth_dropped: assert property (@(posedge clk) disable iff (!rstn)  // R10
    (take && dummy_pos && drop_dummy) |=> !hold_v)
    else $error("ninth byte not dropped");
  a_cell_ends: assert property (@(posedge clk) disable iff (!rstn)  // R13
    consume && byte_idx >= cell_len - 6'h01 |=> state == cell_framer_pkg::TX_IDLE)
    else $error("cell ran past its length");
endmodule : port_tx

// ==========================================================================
// top
module cell_output_port_framing #(
  parameter int NPORTS     = 8,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic [7:0]                    addr,
  input  wire logic [31:0]                   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [31:0]                   rdata,
  output logic                               ctl_oe_n,
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire cell_framer_pkg::cell_byte_t   in_byte,
  input  wire logic [NPORTS-1:0]             out_port_clock,
  output logic      [NPORTS-1:0][3:0]        out_port_nibble,
  output logic      [NPORTS-1:0]             out_port_nibble_oe_n,
  input  wire logic [NPORTS-1:0]             out_cell_marker_i,
  output logic      [NPORTS-1:0]             out_cell_marker_o,
  output logic      [NPORTS-1:0]             out_cell_marker_oe_n,
  input  wire logic                          output_enable_n,
  input  wire logic                          control_output_gate_n,
  input  wire logic                          add_dummy_byte,
  input  wire logic                          drop_dummy_byte
);
  if (NPORTS != 8) $error("port count must be eight");

  logic [5:0]                     cell_len;
  logic [5:0]                     start;
  cell_framer_pkg::group_mode_t   group;
  logic                           cellbus;
  logic                           cfg_control_output_gate;
  logic [NPORTS-1:0]              arb_req;
  logic [NPORTS-1:0]              clk_s;
  logic [NPORTS-1:0]              clk_d;
  logic [NPORTS-1:0]              mark_s;
  logic [3:0]                     pins_s;
  logic                           oe_s;
  logic                           gate_s;
  logic                           add_s;
  logic                           drop_s;
  logic                           narrow;
  logic                           f_valid;
  cell_framer_pkg::cell_byte_t    f_data;
  logic [NPORTS-1:0]              take;
  logic [NPORTS-1:0]              busy;
  logic [NPORTS-1:0]              hold_v;
  cell_framer_pkg::port_out_t     pout [NPORTS];

  // ==========================================================================
  // input synchronisers
  sync2 #(.W(NPORTS)) u_clk_sync  (.clk(clk), .rstn(rstn), .d(out_port_clock), .q(clk_s));
  sync2 #(.W(NPORTS)) u_mark_sync (.clk(clk), .rstn(rstn), .d(out_cell_marker_i), .q(mark_s));
  sync2 #(.W(4)) u_pin_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({!output_enable_n, control_output_gate_n, add_dummy_byte, drop_dummy_byte}),
    .q    (pins_s)
  );
  // enable synced inverted: pins stay released until the pin is seen low
  assign oe_s   = !pins_s[3];  // R12
  assign gate_s = pins_s[2];
  assign add_s  = pins_s[1];
  assign drop_s = pins_s[0];
  assign narrow = (group == cell_framer_pkg::GROUP_X4) || (group == cell_framer_pkg::GROUP_X8);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_d <= '0;
    end else begin
      clk_d <= clk_s;
    end
  end

  // ==========================================================================
  // register bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cell_len  <= `CFG_LEN_RESET;
      start     <= `CFG_START_RESET;
      group     <= cell_framer_pkg::group_mode_t'(`CFG_GROUP_RESET);
      cellbus   <= 1'b0;
      cfg_control_output_gate <= `CFG_CONTROL_OUTPUT_GATE_RESET;
      arb_req   <= '0;
    end else if (wr) begin
      if (addr == `CFG_OFFSET) begin
        cell_len  <= wdata[`CFG_LEN_MSB:`CFG_LEN_LSB];
        start     <= wdata[`CFG_START_MSB:`CFG_START_LSB];
        group     <= cell_framer_pkg::group_mode_t'(wdata[`CFG_GROUP_MSB:`CFG_GROUP_LSB]);
        cellbus   <= wdata[`CFG_CELLBUS_BIT];
        cfg_control_output_gate <= wdata[`CFG_CONTROL_OUTPUT_GATE_BIT];
      end else if (addr == `ARB_OFFSET) begin
        arb_req <= {wdata[NPORTS-1:1], 1'b0};  // R5
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `CFG_OFFSET: begin
          rdata <= '0;
          rdata[`CFG_LEN_MSB:`CFG_LEN_LSB]     <= cell_len;
          rdata[`CFG_START_MSB:`CFG_START_LSB] <= start;
          rdata[`CFG_GROUP_MSB:`CFG_GROUP_LSB] <= group;
          rdata[`CFG_CELLBUS_BIT]              <= cellbus;
          rdata[`CFG_CONTROL_OUTPUT_GATE_BIT]                <= cfg_control_output_gate;
        end
        `ARB_OFFSET:    rdata <= {24'h00_0000, arb_req};
        `STATUS_OFFSET: rdata <= {7'h00, !in_ready, hold_v, mark_s, busy};
        default:        rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // byte fifo and ports
  cell_fifo #(.WIDTH($bits(cell_framer_pkg::cell_byte_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_byte),
    .out_valid (f_valid),
    .out_ready (|take),
    .out_data  (f_data)
  );

  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    logic [2:0] lead;
    logic       sensed;
    // grouped ports follow the leader's clock and marker line
    assign lead   = 3'(i) & ~((3'h1 << group) - 3'h1);  // R7
    assign sensed = mark_s[lead] && !(cellbus && lead != 3'h0);  // R5
    port_tx u_tx (
      .clk        (clk),
      .rstn       (rstn),
      .clk_edge   (clk_s[lead] && !clk_d[lead]),
      .sensed     (sensed),
      .cell_len   (cell_len),
      .start      (start),
      .narrow     (narrow),
      .add_dummy  (add_s),
      .drop_dummy (drop_s),
      .hit        (f_valid && f_data.port == 3'(i)),
      .byte_in    (f_data.data),
      .take       (take[i]),
      .pout       (pout[i]),
      .busy       (busy[i]),
      .hold_v     (hold_v[i])
    );

    // pin registers
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        out_port_nibble[i]      <= 4'h0;
        out_port_nibble_oe_n[i] <= 1'b1;
        out_cell_marker_o[i]    <= 1'b0;
        out_cell_marker_oe_n[i] <= 1'b1;
      end else begin
        out_port_nibble[i]      <= pout[i].nibble;
        out_port_nibble_oe_n[i] <= oe_s;  // R12
        if (cellbus && i != 0) begin
          out_cell_marker_o[i]    <= arb_req[i];  // R5
          out_cell_marker_oe_n[i] <= oe_s || !arb_req[i];
        end else begin
          out_cell_marker_o[i]    <= pout[i].marker;
          out_cell_marker_oe_n[i] <= oe_s || !pout[i].marker || lead != 3'(i);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_oe_n <= 1'b1;
    end else begin
      ctl_oe_n <= gate_s || oe_s || cfg_control_output_gate;  // R8
    end
  end

  a_ctl_gate_off: assert property (@(posedge clk) disable iff (!rstn)  // R8
    !ctl_oe_n |-> !$past(gate_s) && !$past(oe_s) && !$past(cfg_control_output_gate))
    else $error("control outputs driven while gated");
  a_oe_all_off: assert property (@(posedge clk) disable iff (!rstn)  // R12
    oe_s |=> out_port_nibble_oe_n == '1 && out_cell_marker_oe_n == '1 && ctl_oe_n)
    else $error("outputs driven while output enable high");
  a_line0_frame: assert property (@(posedge clk) disable iff (!rstn)  // R5
    cellbus |=> out_cell_marker_o[0] == $past(pout[0].marker))
    else $error("line 0 left frame marker duty");
  a_fifo_full: assert property (@(posedge clk) disable iff (!rstn)
    !in_ready |-> f_valid)
    else $error("fifo refuses while empty");
endmodule : cell_output_port_framing

`default_nettype wire

// *** sim/cell_receiver.sv ***
// downstream cell receiver model: makes port clocks, resolves marker lines, captures cells
`timescale 1ns/1ps
`default_nettype none

module cell_receiver (
  output logic      [7:0]      out_port_clock,
  input  wire logic [7:0][3:0] out_port_nibble,
  input  wire logic [7:0]      out_port_nibble_oe_n,
  input  wire logic [7:0]      out_cell_marker_o,
  input  wire logic [7:0]      out_cell_marker_oe_n,
  output logic      [7:0]      marker_line
);
  logic [7:0] got [0:63];

  // ==========================================================================
  // marker lines are pulled down: high only while a driver pushes them high
  assign marker_line = out_cell_marker_o & ~out_cell_marker_oe_n;

  initial begin
    out_port_clock = '0;
  end

  // one 80 ns port clock period, sampled at the falling edge
  task automatic tick(input int p, input bit pause);
    #40 out_port_clock[p] = 1'b1;
    #40 out_port_clock[p] = 1'b0;
    if (pause) #400;
  endtask : tick

  // clock up to 40 periods to find the marker, then two per byte of the frame; clock stands low otherwise
  task automatic receive(input int p, input int nbytes, input bit pause, output bit framed);
    int         i;
    logic [3:0] nib;
    framed = 1'b0;
    for (i = 0; i < 40 && !framed; i++) begin
      tick(p, 1'b0);
      framed = marker_line[p];
    end
    for (i = 0; i < 2 * nbytes; i++) begin
      tick(p, pause && i == 3);
      nib = out_port_nibble_oe_n[p] ? 4'hX : out_port_nibble[p];
      if (i % 2 == 0) begin
        got[i / 2] = {nib, 4'h0};
      end else begin
        got[i / 2] = {got[i / 2][7:4], nib};
      end
    end
  endtask : receive
endmodule : cell_receiver

`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking testbench of the cell output framer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct {
    logic [2:0] p;
    int         len;
    bit         add;
    bit         drop;
    bit         pause;
  } row_t;

  logic                         clk;
  logic                         rstn;
  logic [7:0]                   addr;
  logic [31:0]                  wdata;
  logic                         wr;
  logic                         rd;
  logic [31:0]                  rdata;
  logic                         ctl_oe_n;
  logic                         in_valid;
  logic                         in_ready;
  cell_framer_pkg::cell_byte_t  in_byte;
  logic [7:0]                   out_port_clock;
  logic [7:0][3:0]              out_port_nibble;
  logic [7:0]                   out_port_nibble_oe_n;
  logic [7:0]                   marker_line;
  logic [7:0]                   out_cell_marker_o;
  logic [7:0]                   out_cell_marker_oe_n;
  logic                         output_enable_n;
  logic                         control_output_gate_n;
  logic                         add_dummy_byte;
  logic                         drop_dummy_byte;
  int                           mismatches;
  int                           samples_checked;
  logic [31:0]                  rv;
  logic [7:0]                   exp_b [0:63];
  bit                           framed;
  row_t                         rows [0:10];

  cell_output_port_framing cell_output_port_framing_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ctl_oe_n(ctl_oe_n), .in_valid(in_valid), .in_ready(in_ready), .in_byte(in_byte),
    .out_port_clock(out_port_clock), .out_port_nibble(out_port_nibble),
    .out_port_nibble_oe_n(out_port_nibble_oe_n), .out_cell_marker_i(marker_line),
    .out_cell_marker_o(out_cell_marker_o), .out_cell_marker_oe_n(out_cell_marker_oe_n),
    .output_enable_n(output_enable_n), .control_output_gate_n(control_output_gate_n),
    .add_dummy_byte(add_dummy_byte), .drop_dummy_byte(drop_dummy_byte));

  cell_receiver cell_receiver_inst (
    .out_port_clock(out_port_clock), .out_port_nibble(out_port_nibble),
    .out_port_nibble_oe_n(out_port_nibble_oe_n), .out_cell_marker_o(out_cell_marker_o),
    .out_cell_marker_oe_n(out_cell_marker_oe_n), .marker_line(marker_line));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // helpers
  task automatic end_of_test();
    $display("compared %0d values, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : bus_read

  task automatic send_byte(input logic [2:0] p, input logic [7:0] d);
    int n;
    in_byte  <= '{port: p, data: d};
    in_valid <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (in_ready === 1'b1) break;
    end
    @(posedge clk);
    in_valid <= 1'b0;
    if (n == 4000) begin
      mismatches++;
      end_of_test();
    end
    @(posedge clk);
  endtask : send_byte

  function automatic logic [7:0] pat(input logic [2:0] p, input int k);
    return {p, 5'(k)} ^ 8'h5A;
  endfunction : pat

  // one cell through port p; add and drop pins only change while ports are idle
  task automatic run_cell(input row_t r);
    int i;
    int j;
    int nfeed;
    nfeed = r.add ? r.len - 1 : (r.drop ? r.len + 1 : r.len);
    add_dummy_byte  <= r.add;
    drop_dummy_byte <= r.drop;
    bus_write(`CFG_OFFSET, 32'(r.len));
    bus_read(`CFG_OFFSET, rv);
    check("config", 32'(r.len), rv);
    j = 0;
    for (i = 0; i < r.len; i++) begin
      if (r.add && i == 8) begin
        exp_b[i] = `DUMMY_BYTE_VALUE;
      end else begin
        if (r.drop && j == 8) j++;
        exp_b[i] = pat(r.p, j);
        j++;
      end
    end
    fork
      for (int k = 0; k < nfeed; k++) send_byte(r.p, pat(r.p, k));
      cell_receiver_inst.receive(int'(r.p), r.len, r.pause, framed);
    join
    @(posedge clk);
    check("marker seen", 32'h1, 32'(framed));
    for (i = 0; i < r.len; i++) begin
      check("cell byte", 32'(exp_b[i]), 32'(cell_receiver_inst.got[i]));
    end
    $display("test cell port %0d len %0d done", r.p, r.len);
  endtask : run_cell

  // ==========================================================================
  // main sequence
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    in_valid = 1'b0;
    in_byte = '0;
    output_enable_n = 1'b0;
    control_output_gate_n = 1'b0;
    add_dummy_byte = 1'b0;
    drop_dummy_byte = 1'b0;
    rows = '{'{3'h0, 4, 0, 0, 0}, '{3'h1, 4, 0, 0, 1}, '{3'h2, 4, 0, 0, 0},
             '{3'h3, 5, 0, 0, 0}, '{3'h4, 4, 0, 0, 0}, '{3'h5, 4, 0, 0, 1},
             '{3'h6, 4, 0, 0, 0}, '{3'h7, 6, 0, 0, 0}, '{3'h2, 10, 1, 0, 0},
             '{3'h5, 10, 0, 1, 1}, '{3'h5, 10, 0, 1, 0}};
    repeat (16) @(posedge clk);
    check("nibble oe_n in reset", 32'hFF, 32'(out_port_nibble_oe_n));
    check("ctl oe_n in reset", 32'h1, 32'(ctl_oe_n));
    check("ready in reset", 32'h1, 32'(in_ready));
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) run_cell(rows[i]);
    // control output gating
    repeat (5) @(posedge clk);
    check("ctl oe_n all low", 32'h0, 32'(ctl_oe_n));
    control_output_gate_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("ctl oe_n gate high", 32'h1, 32'(ctl_oe_n));
    control_output_gate_n <= 1'b0;
    bus_write(`CFG_OFFSET, 32'h0100_0004);
    repeat (5) @(posedge clk);
    check("ctl oe_n config bit", 32'h1, 32'(ctl_oe_n));
    $display("test control gating done");
    // output enable released
    output_enable_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("nibble oe_n released", 32'hFF, 32'(out_port_nibble_oe_n));
    check("marker oe_n released", 32'hFF, 32'(out_cell_marker_oe_n));
    check("ctl oe_n released", 32'h1, 32'(ctl_oe_n));
    output_enable_n <= 1'b0;
    $display("test output enable done");
    // cell bus arbitration and unmapped address
    bus_write(`ARB_OFFSET, 32'hFF);
    bus_write(`CFG_OFFSET, 32'h0010_0004);
    repeat (5) @(posedge clk);
    check("arbitration drive", 32'h7F, 32'(out_cell_marker_o[7:1]));
    check("arbitration enable", 32'h7F, {25'h0, ~out_cell_marker_oe_n[7:1]});
    bus_read(`ARB_OFFSET, rv);
    check("arbitration register", 32'hFE, rv);
    bus_read(8'h0C, rv);
    check("unmapped read", 32'h0, rv);
    $display("test cell bus done");
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
